// file: core/sacp_pkg.sv
// Purpose: shared constants for the set associative cache controller
// Assumes: 32-bit addresses and data, 32-byte lines of eight words
// Notes: register offsets are byte addresses on the plain register port
package sacp_pkg;
  // ---------------------------------------------------------------
  // address split
  // ---------------------------------------------------------------
  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;
  localparam int LINE_BYTES = 32;
  localparam int WORD_BYTES = 4;
  localparam int WORDS = LINE_BYTES / WORD_BYTES;
  localparam int BYTE_W = 2;
  localparam int WORD_W = 3;
  localparam int OFS_W = BYTE_W + WORD_W;
  localparam int IDX_LSB = OFS_W;
  localparam logic [3:0] BE_ALL = 4'hf;
  localparam logic [WORD_W-1:0] LAST_BEAT = 3'h7;

  // ---------------------------------------------------------------
  // register port
  // ---------------------------------------------------------------
  localparam int RADDR_W = 8;
  localparam logic [7:0] REG_LOCK = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_MISSES = 8'h08;
  localparam int LOCK_W = 8;
  localparam logic [7:0] LOCK_RST = 8'h00;
  localparam logic [31:0] MISS_RST = 32'h0000_0000;
  localparam logic [31:0] RD_ZERO = 32'h0000_0000;

  // ---------------------------------------------------------------
  // controller states
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_LOOK = 3'b001,
    S_WB = 3'b010,
    S_FILL = 3'b011,
    S_WRMEM = 3'b100,
    S_RDMEM = 3'b101
  } sacp_state_e;
endpackage

// file: core/sacp_cache.sv
// Purpose: set associative cache controller with modified LRU policy
// Assumes: memory bus on sys_clk_i, one word per mem_ack_i
// Notes: one access in flight; an allocating miss fills then replays the lookup
// How it works
// - evict least recently used participating line
// - per-line retention priority overrides plain recency
// - low incoming evicts only low lines
// - high incoming prefers low, else high lines
// - reset clears every valid flag
// - miss fetches line into chosen way
// - valid set after complete line fill
// - tag compare on valid lines gives hit
// - address splits into tag, index, offset
// - write-through hit updates cache and memory
// - write-back hit updates cache only
// - store writes only the modified word
// - dirty flag; clean victims not written back
// - write-allocate fills then stores as hit
// - no-write-allocate miss touches memory only
// - a line holds 32 bytes
// - locked ways never chosen as victim
`timescale 1ns/1ns
module sacp_cache #(
  parameter int WAYS = 4,
  parameter int IDX_W = 4
) (
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic cpu_req_i,
  input wire logic cpu_we_i,
  input wire logic [31:0] cpu_addr_i,
  input wire logic [31:0] cpu_wdata_i,
  input wire logic [3:0] cpu_be_i,
  input wire logic cpu_wt_i,
  input wire logic cpu_walloc_i,
  input wire logic cpu_line_retention_priority_i,
  output logic cpu_ready_o,
  output logic cpu_done_o,
  output logic [31:0] cpu_rdata_o,
  output logic mem_req_o,
  output logic mem_we_o,
  output logic [31:0] mem_addr_o,
  output logic [31:0] mem_wdata_o,
  output logic [3:0] mem_be_o,
  input wire logic mem_ack_i,
  input wire logic [31:0] mem_rdata_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o
);
  localparam int SETS = 1 << IDX_W;
  localparam int WAY_W = $clog2(WAYS);
  localparam int TAG_W = sacp_pkg::ADDR_W - IDX_W - sacp_pkg::OFS_W;
  localparam int DI_W = IDX_W + WAY_W + sacp_pkg::WORD_W;
  localparam int WW = sacp_pkg::WORD_W;

  // ---------------------------------------------------------------
  // line state and storage
  // ---------------------------------------------------------------
  logic [WAYS-1:0] valid_q [SETS];
  logic [WAYS-1:0] dirty_q [SETS];
  logic [WAYS-1:0] lprio_q [SETS];
  logic [TAG_W-1:0] tag_q [SETS][WAYS];
  logic [WAY_W-1:0] age_q [SETS][WAYS];
  logic [31:0] data_q [1 << DI_W];

  sacp_pkg::sacp_state_e state_q, state_d;
  logic [31:0] addr_q, addr_d, wdata_q, wdata_d;
  logic [3:0] be_q, be_d;
  logic we_q, we_d, wt_q, wt_d, walloc_q, walloc_d, inprio_q, inprio_d;
  logic [WW-1:0] beat_q, beat_d;
  logic [WAY_W-1:0] way_q, way_d;
  logic ready_q, ready_d, done_q, done_d;
  logic [31:0] rdata_q, rdata_d;
  logic mreq_q, mreq_d, mwe_q, mwe_d;
  logic [31:0] maddr_q, maddr_d, mwdata_q, mwdata_d;
  logic [3:0] mbe_q, mbe_d;
  logic [WAYS-1:0] lock_q, lock_d;
  logic [31:0] miss_q, miss_d, regrd_q, regrd_d;

  // array write controls
  logic touch, meta_fill, set_dirty, data_we;
  logic [DI_W-1:0] data_idx;
  logic [31:0] data_wval;
  logic [3:0] data_wmask;

  // ---------------------------------------------------------------
  // lookup and victim choice
  // ---------------------------------------------------------------
  logic [IDX_W-1:0] idx;
  logic [TAG_W-1:0] tag;
  logic [WW-1:0] word;
  logic [WAYS-1:0] hit_vec, cand_lo, cand, inv;
  logic hit, older;
  logic [WAY_W-1:0] hit_way, victim;

  assign tag = addr_q[31 -: TAG_W];
  assign idx = addr_q[sacp_pkg::IDX_LSB +: IDX_W];
  assign word = addr_q[sacp_pkg::BYTE_W +: WW];

  always_comb begin
    hit_vec = '0;
    hit_way = '0;
    for (int w = 0; w < WAYS; w++) begin
      hit_vec[w] = valid_q[idx][w] && (tag_q[idx][w] == tag);
      if (hit_vec[w]) begin
        hit_way = WAY_W'(w);
      end
    end
    hit = |hit_vec;
    // invalid ways read as low priority since reset clears both flags
    cand_lo = ~lock_q & (~valid_q[idx] | ~lprio_q[idx]);
    if (inprio_q && cand_lo == '0) begin
      cand = ~lock_q;
    end else begin
      cand = cand_lo;
    end
    inv = cand & ~valid_q[idx];
    victim = '0;
    for (int w = WAYS - 1; w >= 0; w--) begin
      if (inv[w]) begin
        victim = WAY_W'(w);
      end
    end
    if (inv == '0) begin
      for (int w = 0; w < WAYS; w++) begin
        if (cand[w] && (!cand[victim] ||
            age_q[idx][w] > age_q[idx][victim])) begin
          victim = WAY_W'(w);
        end
      end
    end
    older = 1'b0;
    for (int w = 0; w < WAYS; w++) begin
      if (cand[w] && inv == '0 && age_q[idx][w] > age_q[idx][victim]) begin
        older = 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // controller next state
  // ---------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    addr_d = addr_q;
    wdata_d = wdata_q;
    be_d = be_q;
    we_d = we_q;
    wt_d = wt_q;
    walloc_d = walloc_q;
    inprio_d = inprio_q;
    beat_d = beat_q;
    way_d = way_q;
    ready_d = ready_q;
    done_d = 1'b0;
    rdata_d = rdata_q;
    mreq_d = mreq_q;
    mwe_d = mwe_q;
    maddr_d = maddr_q;
    mwdata_d = mwdata_q;
    mbe_d = mbe_q;
    lock_d = lock_q;
    miss_d = miss_q;
    touch = 1'b0;
    meta_fill = 1'b0;
    set_dirty = 1'b0;
    data_we = 1'b0;
    data_idx = {idx, hit_way, word};
    data_wval = wdata_q;
    data_wmask = be_q;
    case (state_q)
      sacp_pkg::S_IDLE: begin
        if (cpu_req_i) begin
          addr_d = cpu_addr_i;
          wdata_d = cpu_wdata_i;
          be_d = cpu_be_i;
          we_d = cpu_we_i;
          wt_d = cpu_wt_i;
          walloc_d = cpu_walloc_i;
          inprio_d = cpu_line_retention_priority_i;
          ready_d = 1'b0;
          state_d = sacp_pkg::S_LOOK;
        end
      end
      sacp_pkg::S_LOOK: begin
        if (hit) begin
          touch = 1'b1;
          if (!we_q) begin
            rdata_d = data_q[{idx, hit_way, word}];
            done_d = 1'b1;
            ready_d = 1'b1;
            state_d = sacp_pkg::S_IDLE;
          end else begin
            data_we = 1'b1;
            if (wt_q) begin
              // only the stored word goes out, never the line
              mreq_d = 1'b1;
              mwe_d = 1'b1;
              maddr_d = addr_q;
              mwdata_d = wdata_q;
              mbe_d = be_q;
              state_d = sacp_pkg::S_WRMEM;
            end else begin
              set_dirty = 1'b1;
              done_d = 1'b1;
              ready_d = 1'b1;
              state_d = sacp_pkg::S_IDLE;
            end
          end
        end else begin
          miss_d = miss_q + 32'h0000_0001;
          mreq_d = 1'b1;
          mbe_d = sacp_pkg::BE_ALL;
          beat_d = '0;
          way_d = victim;
          if ((we_q && !walloc_q) || cand == '0) begin
            // no allocation: the access goes straight to memory
            mwe_d = we_q;
            maddr_d = addr_q;
            mwdata_d = wdata_q;
            mbe_d = we_q ? be_q : sacp_pkg::BE_ALL;
            state_d = we_q ? sacp_pkg::S_WRMEM : sacp_pkg::S_RDMEM;
          end else if (valid_q[idx][victim] && dirty_q[idx][victim]) begin
            mwe_d = 1'b1;
            maddr_d = {tag_q[idx][victim], idx, WW'(0), 2'b00};
            mwdata_d = data_q[{idx, victim, WW'(0)}];
            state_d = sacp_pkg::S_WB;
          end else begin
            mwe_d = 1'b0;
            maddr_d = {tag, idx, WW'(0), 2'b00};
            state_d = sacp_pkg::S_FILL;
          end
        end
      end
      sacp_pkg::S_WB: begin
        if (mem_ack_i) begin
          beat_d = beat_q + WW'(1);
          if (beat_q == sacp_pkg::LAST_BEAT) begin
            mwe_d = 1'b0;
            maddr_d = {tag, idx, WW'(0), 2'b00};
            state_d = sacp_pkg::S_FILL;
          end else begin
            maddr_d = {maddr_q[31:5], beat_d, 2'b00};
            mwdata_d = data_q[{idx, way_q, beat_d}];
          end
        end
      end
      sacp_pkg::S_FILL: begin
        if (mem_ack_i) begin
          data_we = 1'b1;
          data_idx = {idx, way_q, beat_q};
          data_wval = mem_rdata_i;
          data_wmask = sacp_pkg::BE_ALL;
          beat_d = beat_q + WW'(1);
          if (beat_q == sacp_pkg::LAST_BEAT) begin
            meta_fill = 1'b1;
            mreq_d = 1'b0;
            // replay: a store then completes as a hit
            state_d = sacp_pkg::S_LOOK;
          end else begin
            maddr_d = {maddr_q[31:5], beat_d, 2'b00};
          end
        end
      end
      sacp_pkg::S_WRMEM, sacp_pkg::S_RDMEM: begin
        if (mem_ack_i) begin
          mreq_d = 1'b0;
          if (state_q == sacp_pkg::S_RDMEM) begin
            rdata_d = mem_rdata_i;
          end
          done_d = 1'b1;
          ready_d = 1'b1;
          state_d = sacp_pkg::S_IDLE;
        end
      end
      default: begin
        state_d = sacp_pkg::S_IDLE;
      end
    endcase
    regrd_d = sacp_pkg::RD_ZERO;
    if (reg_wr_i && reg_addr_i == sacp_pkg::REG_LOCK) begin
      lock_d = reg_wdata_i[WAYS-1:0];
    end
    if (!reg_rd_i) begin
      regrd_d = sacp_pkg::RD_ZERO;
    end else if (reg_addr_i == sacp_pkg::REG_LOCK) begin
      regrd_d = 32'(lock_q);
    end else if (reg_addr_i == sacp_pkg::REG_STATUS) begin
      regrd_d = {28'h000_0000, !ready_q, state_q};
    end else if (reg_addr_i == sacp_pkg::REG_MISSES) begin
      regrd_d = miss_q;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_q <= sacp_pkg::S_IDLE;
      addr_q <= 32'h0000_0000;
      wdata_q <= 32'h0000_0000;
      be_q <= 4'h0;
      we_q <= 1'b0;
      wt_q <= 1'b0;
      walloc_q <= 1'b0;
      inprio_q <= 1'b0;
      beat_q <= '0;
      way_q <= '0;
      ready_q <= 1'b1;
      done_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      mreq_q <= 1'b0;
      mwe_q <= 1'b0;
      maddr_q <= 32'h0000_0000;
      mwdata_q <= 32'h0000_0000;
      mbe_q <= 4'h0;
      lock_q <= sacp_pkg::LOCK_RST[WAYS-1:0];
      miss_q <= sacp_pkg::MISS_RST;
      regrd_q <= sacp_pkg::RD_ZERO;
    end else begin
      state_q <= state_d;
      addr_q <= addr_d;
      wdata_q <= wdata_d;
      be_q <= be_d;
      we_q <= we_d;
      wt_q <= wt_d;
      walloc_q <= walloc_d;
      inprio_q <= inprio_d;
      beat_q <= beat_d;
      way_q <= way_d;
      ready_q <= ready_d;
      done_q <= done_d;
      rdata_q <= rdata_d;
      mreq_q <= mreq_d;
      mwe_q <= mwe_d;
      maddr_q <= maddr_d;
      mwdata_q <= mwdata_d;
      mbe_q <= mbe_d;
      lock_q <= lock_d;
      miss_q <= miss_d;
      regrd_q <= regrd_d;
    end
  end

  // ---------------------------------------------------------------
  // array updates
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      for (int s = 0; s < SETS; s++) begin
        valid_q[s] <= '0;
        dirty_q[s] <= '0;
        lprio_q[s] <= '0;
        for (int w = 0; w < WAYS; w++) begin
          age_q[s][w] <= WAY_W'(w);
        end
      end
    end else begin
      if (meta_fill) begin
        valid_q[idx][way_q] <= 1'b1;
        dirty_q[idx][way_q] <= 1'b0;
        lprio_q[idx][way_q] <= inprio_q;
      end
      if (set_dirty) begin
        dirty_q[idx][hit_way] <= 1'b1;
      end
      if (touch) begin
        for (int w = 0; w < WAYS; w++) begin
          if (age_q[idx][w] < age_q[idx][hit_way]) begin
            age_q[idx][w] <= age_q[idx][w] + WAY_W'(1);
          end
        end
        age_q[idx][hit_way] <= '0;
      end
    end
  end

  // tags and data need no reset; valid guards them
  always_ff @(posedge sys_clk_i) begin
    if (meta_fill) begin
      tag_q[idx][way_q] <= tag;
    end
    if (data_we) begin
      for (int b = 0; b < 4; b++) begin
        if (data_wmask[b]) begin
          data_q[data_idx][8*b +: 8] <= data_wval[8*b +: 8];
        end
      end
    end
  end

  assign cpu_ready_o = ready_q;
  assign cpu_done_o = done_q;
  assign cpu_rdata_o = rdata_q;
  assign mem_req_o = mreq_q;
  assign mem_we_o = mwe_q;
  assign mem_addr_o = maddr_q;
  assign mem_wdata_o = mwdata_q;
  assign mem_be_o = mbe_q;
  assign reg_rdata_o = regrd_q;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);
  logic alloc;
  assign alloc = state_q == sacp_pkg::S_LOOK && !hit && cand != '0 &&
                 !(we_q && !walloc_q);

  hit_valid_a: assert property (hit |-> valid_q[idx][hit_way] &&
    tag_q[idx][hit_way] == tag) else $error("hit on an invalid line");
  lock_excl_a: assert property (alloc |-> !lock_q[victim])
    else $error("locked way chosen as victim");
  low_prio_a: assert property (alloc && !inprio_q |->
    !(valid_q[idx][victim] && lprio_q[idx][victim]))
    else $error("low line evicts a high line");
  high_prio_a: assert property (alloc && cand_lo != '0 |->
    cand_lo[victim]) else $error("high line evicted while low exists");
  lru_pick_a: assert property (alloc |-> !older)
    else $error("victim is not least recently used");
  wb_first_a: assert property (alloc && valid_q[idx][victim] &&
    dirty_q[idx][victim] |=> state_q == sacp_pkg::S_WB && mem_we_o)
    else $error("dirty victim not written back first");
  wt_store_a: assert property (hit && we_q && wt_q &&
    state_q == sacp_pkg::S_LOOK |=> mem_req_o && mem_we_o &&
    mem_addr_o == $past(addr_q)) else $error("write-through hit missed");
  wb_store_a: assert property (hit && we_q && !wt_q &&
    state_q == sacp_pkg::S_LOOK |=> cpu_done_o && !mem_req_o &&
    dirty_q[$past(idx)][$past(hit_way)]) else $error("write-back hit wrong");
  no_alloc_a: assert property (state_q == sacp_pkg::S_LOOK && !hit &&
    we_q && !walloc_q |=> state_q == sacp_pkg::S_WRMEM &&
    valid_q[idx] == $past(valid_q[idx]) && !meta_fill)
    else $error("no-allocate miss changed cache");
  fill_valid_a: assert property (state_q == sacp_pkg::S_FILL &&
    mem_ack_i && beat_q == sacp_pkg::LAST_BEAT |=> valid_q[idx][way_q] &&
    state_q == sacp_pkg::S_LOOK ##1 hit) else $error("fill left line bad");

  read_hit_c: cover property (hit && !we_q && state_q == sacp_pkg::S_LOOK);
  wb_c: cover property (state_q == sacp_pkg::S_WB ##1 1'b1);
  uncached_c: cover property (state_q == sacp_pkg::S_RDMEM && mem_ack_i);
  wt_c: cover property (state_q == sacp_pkg::S_WRMEM && mem_ack_i && wt_q);
endmodule // sacp_cache

// file: tb/sacp_mem_model.sv
// Purpose: lower-level memory seen by the cache controller
// Assumes: one word per ack, ack is a one-cycle pulse
// Notes: slow_i adds a wait of one to three cycles before each ack
`timescale 1ns/1ns
module sacp_mem_model (
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic slow_i,
  input wire logic req_i,
  input wire logic we_i,
  input wire logic [31:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic [3:0] be_i,
  output logic ack_o,
  output logic [31:0] rdata_o
);
  logic [31:0] mem [int];
  logic [31:0] last_addr;
  logic [3:0] last_be;
  logic [31:0] w;
  int rd_cnt = 0;
  int wr_cnt = 0;
  int wait_q;

  function automatic logic [31:0] peek(input logic [31:0] a);
    if (mem.exists(int'(a[31:2]))) return mem[int'(a[31:2])];
    return {a[15:0], ~a[15:0]};
  endfunction

  // rdata is inverted off the ack so a stale word never looks valid
  always @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ack_o <= 1'b0;
      rdata_o <= 32'h0000_0000;
      wait_q <= 0;
    end else if (ack_o) begin
      ack_o <= 1'b0;
      rdata_o <= ~rdata_o;
      if (we_i) begin
        wr_cnt++;
        last_addr = addr_i;
        last_be = be_i;
        w = peek(addr_i);
        for (int b = 0; b < 4; b++) if (be_i[b]) w[8*b +: 8] = wdata_i[8*b +: 8];
        mem[int'(addr_i[31:2])] = w;
      end else begin
        rd_cnt++;
      end
    end else if (req_i && wait_q >= (slow_i ? addr_i[4:2] % 3 + 1 : 0)) begin
      ack_o <= 1'b1;
      wait_q <= 0;
      if (!we_i) rdata_o <= peek(addr_i);
    end else begin
      wait_q <= req_i ? wait_q + 1 : 0;
      rdata_o <= ~rdata_o;
    end
  end
endmodule // sacp_mem_model

// file: tb/set_assoc_cache_policy_tb_top.sv
// Purpose: self-checking bench for the cache controller
// Assumes: reference memory is flat, so loads must always match it
// Notes: beat counts per access tell hit, fill, write-back, uncached
`timescale 1ns/1ns
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin \
  errors++; $display("[ERR] %0t got %0h exp %0h", $time, got, exp); end end
module set_assoc_cache_policy_tb_top;
  logic sys_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic cpu_req_i = 1'b0, cpu_we_i = 1'b0, cpu_wt_i = 1'b0;
  logic cpu_walloc_i = 1'b0, cpu_line_retention_priority_i = 1'b0;
  logic [31:0] cpu_addr_i = 32'h0000_0000, cpu_wdata_i = 32'h0000_0000;
  logic [3:0] cpu_be_i = 4'h0, mem_be_o;
  logic cpu_ready_o, cpu_done_o, mem_req_o, mem_we_o, mem_ack_i;
  logic [31:0] cpu_rdata_o, mem_addr_o, mem_wdata_o, mem_rdata_i, reg_rdata_o;
  logic [7:0] reg_addr_i = 8'h00;
  logic [31:0] reg_wdata_i = 32'h0000_0000;
  logic reg_wr_i = 1'b0, reg_rd_i = 1'b0, slow = 1'b0;
  logic [31:0] ref_mem [int];
  logic [31:0] r;
  int errors = 0, compares = 0, cycles = 0;
  int seed = 32'h0000_f10a;

  sacp_cache uut (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
    .cpu_req_i(cpu_req_i), .cpu_we_i(cpu_we_i), .cpu_addr_i(cpu_addr_i),
    .cpu_wdata_i(cpu_wdata_i), .cpu_be_i(cpu_be_i), .cpu_wt_i(cpu_wt_i),
    .cpu_walloc_i(cpu_walloc_i),
    .cpu_line_retention_priority_i(cpu_line_retention_priority_i),
    .cpu_ready_o(cpu_ready_o), .cpu_done_o(cpu_done_o),
    .cpu_rdata_o(cpu_rdata_o), .mem_req_o(mem_req_o), .mem_we_o(mem_we_o),
    .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o), .mem_be_o(mem_be_o),
    .mem_ack_i(mem_ack_i), .mem_rdata_i(mem_rdata_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o));
  sacp_mem_model mem (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
    .slow_i(slow), .req_i(mem_req_o), .we_i(mem_we_o), .addr_i(mem_addr_o),
    .wdata_i(mem_wdata_o), .be_i(mem_be_o), .ack_o(mem_ack_i),
    .rdata_o(mem_rdata_i));

  initial begin
    forever #4 sys_clk_i = ~sys_clk_i;
  end

  task automatic results;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // hang guard: the whole run needs far fewer cycles
  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 80000) begin
      errors++;
      results();
    end
  end

  function automatic logic [31:0] la(input int t, input int s);
    return {t[22:0], s[3:0], 5'h00};
  endfunction

  function automatic logic [31:0] rpeek(input logic [31:0] a);
    if (ref_mem.exists(int'(a[31:2]))) return ref_mem[int'(a[31:2])];
    return {a[15:0], ~a[15:0]};
  endfunction

  // er/ew: expected read/write beats, negative er means neither is checked
  task automatic acc(input logic we, input logic [31:0] a,
    input logic [3:0] be, input logic wt, input logic wa, input logic pr,
    input int er, input int ew);
    int r0, w0, n;
    logic [31:0] d, w;
    r0 = mem.rd_cnt;
    w0 = mem.wr_cnt;
    d = $random(seed);
    cpu_req_i <= 1'b1;
    cpu_we_i <= we;
    cpu_addr_i <= a;
    cpu_wdata_i <= d;
    cpu_be_i <= be;
    cpu_wt_i <= wt;
    cpu_walloc_i <= wa;
    cpu_line_retention_priority_i <= pr;
    @(posedge sys_clk_i);
    cpu_req_i <= 1'b0;
    n = 0;
    do begin
      @(posedge sys_clk_i);
      n++;
      if (n == 1) `CHK(cpu_ready_o, 1'b0)
    end while (cpu_done_o !== 1'b1 && n < 400);
    if (n >= 400) begin
      errors++;
      results();
    end
    `CHK(cpu_ready_o, 1'b1)
    if (we) begin
      w = rpeek(a);
      for (int b = 0; b < 4; b++) if (be[b]) w[8*b +: 8] = d[8*b +: 8];
      ref_mem[int'(a[31:2])] = w;
    end else `CHK(cpu_rdata_o, rpeek(a))
    if (er >= 0) begin
      `CHK(mem.rd_cnt - r0, er)
      `CHK(mem.wr_cnt - w0, ew)
    end
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] v);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= v;
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b0;
  endtask

  task automatic reg_chk(input logic [7:0] a, input logic [31:0] v);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b0;
    @(posedge sys_clk_i);
    `CHK(reg_rdata_o, v)
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (12) @(posedge sys_clk_i);
    rst_b_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_chk(sacp_pkg::REG_LOCK, 32'h0000_0000);
    reg_chk(sacp_pkg::REG_MISSES, sacp_pkg::MISS_RST);
    acc(0, la(1, 1), 4'hf, 0, 1, 1, 8, 0);
    acc(0, la(1, 1) + 4, 4'hf, 0, 1, 1, 0, 0);
    acc(1, la(1, 1) + 8, 4'h3, 1, 1, 1, 0, 1);
    `CHK(mem.last_be, 4'h3)
    `CHK(mem.last_addr, la(1, 1) + 8)
    acc(1, la(1, 1) + 12, 4'hf, 0, 1, 1, 0, 0);
    for (int t = 2; t <= 4; t++) acc(0, la(t, 1), 4'hf, 0, 1, 1, 8, 0);
    acc(0, la(1, 1), 4'hf, 0, 1, 1, 0, 0);
    acc(0, la(5, 1), 4'hf, 0, 1, 1, 8, 0);
    acc(0, la(2, 1), 4'hf, 0, 1, 1, 8, 0);
    acc(0, la(6, 1), 4'hf, 0, 1, 1, 8, 0);
    acc(0, la(7, 1), 4'hf, 0, 1, 1, 8, 8);
    acc(0, la(1, 1) + 12, 4'hf, 0, 1, 1, 8, 0);
    acc(1, la(8, 1) + 4, 4'hf, 0, 0, 1, 0, 1);
    acc(0, la(8, 1) + 4, 4'hf, 0, 1, 1, 8, 0);
    acc(1, la(9, 2) + 4, 4'hf, 1, 1, 1, 8, 1);
    acc(0, la(9, 2) + 4, 4'hf, 0, 1, 1, 0, 0);
    for (int t = 1; t <= 4; t++) acc(0, la(t, 3), 4'hf, 0, 1, 1, 8, 0);
    repeat (2) acc(0, la(5, 3), 4'hf, 0, 1, 0, 1, 0);
    acc(0, la(6, 3), 4'hf, 0, 1, 1, 8, 0);
    acc(0, la(2, 3), 4'hf, 0, 1, 1, 0, 0);
    acc(0, la(1, 4), 4'hf, 0, 1, 0, 8, 0);
    for (int t = 2; t <= 4; t++) acc(0, la(t, 4), 4'hf, 0, 1, 1, 8, 0);
    acc(0, la(1, 4), 4'hf, 0, 1, 0, 0, 0);
    acc(0, la(5, 4), 4'hf, 0, 1, 1, 8, 0);
    acc(0, la(2, 4), 4'hf, 0, 1, 1, 0, 0);
    acc(0, la(1, 4), 4'hf, 0, 1, 0, 1, 0);
    reg_wr(sacp_pkg::REG_LOCK, 32'h0000_000f);
    reg_chk(sacp_pkg::REG_LOCK, 32'h0000_000f);
    reg_wr(sacp_pkg::REG_STATUS, 32'hffff_ffff);
    reg_chk(sacp_pkg::REG_STATUS, 32'h0000_0000);
    reg_chk(8'h0c, 32'h0000_0000);
    acc(0, la(7, 3), 4'hf, 0, 1, 1, 1, 0);
    acc(0, la(6, 3), 4'hf, 0, 1, 1, 0, 0);
    // 26 of the 35 directed lookups above miss
    reg_chk(sacp_pkg::REG_MISSES, 32'h0000_001a);
    reg_wr(sacp_pkg::REG_LOCK, 32'h0000_0000);
    // random mix on two sets, data checked against flat memory
    slow <= 1'b1;
    repeat (300) begin
      r = $random(seed);
      acc(r[0], la(1 + r[3:1] % 6, 5 + r[4]) + {r[7:5], 2'b00},
        (r[11:8] == 4'h0) ? 4'hf : r[11:8], r[12], r[13], r[14], -1, -1);
    end
    results();
  end
endmodule // set_assoc_cache_policy_tb_top
